// ===== hw/fmau_top.sv
// Fused multiply-add/subtract execution unit with an AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module fmau_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output wire logic hreadyout,
  output wire logic hresp,
  output wire logic [31:0] hrdata,
  // Interrupt
  output wire logic irq
);

  fmau_pkg::fmau_regs_t r;
  fmau_pkg::fmau_regs_t n;

  // Weight of the lowest bit of the wide sum, counted down from the product exponent.
  localparam logic signed [12:0] PROD_SCALE_TOP = fmau_pkg::PROD_SCALE + 13'(fmau_pkg::GUARD);

  // Splits an operand into fields and class bits; a single value sits in the low word.
  function automatic fmau_pkg::fmau_fp_t unpack(input logic [63:0] x, input logic dbl);
    fmau_pkg::fmau_fp_t u;
    logic [10:0] emax;
    u.sign = dbl ? x[63] : x[31];
    u.ex = dbl ? x[62:52] : {3'h0, x[30:23]};
    u.fr = dbl ? x[51:0] : {x[22:0], {fmau_pkg::FPAD{1'b0}}};
    emax = dbl ? fmau_pkg::EMAX_D : fmau_pkg::EMAX_S;
    u.zero = (u.ex == 11'h000) && (u.fr == 52'h0);
    u.den = (u.ex == 11'h000) && (u.fr != 52'h0);
    u.inf = (u.ex == emax) && (u.fr == 52'h0);
    u.nan = (u.ex == emax) && (u.fr != 52'h0);
    u.snan = u.nan && !u.fr[51];
    u.m = {u.ex != 11'h000, u.fr};
    u.e = $signed({2'h0, u.ex}) - (dbl ? fmau_pkg::BIAS_D : fmau_pkg::BIAS_S);
    return u;
  endfunction

  // Builds a result word; a single result leaves the high word zero.
  function automatic logic [63:0] pack(input logic s, input logic [10:0] ex, input logic [51:0] fr,
                                       input logic dbl);
    return dbl ? {s, ex, fr} : {32'h0, s, ex[fmau_pkg::EWS-1:0], fr[51:fmau_pkg::FPAD]};
  endfunction

  // Right shift that folds every lost bit into the lowest bit.
  function automatic logic [215:0] shr_sticky(input logic [215:0] v, input logic signed [12:0] amt);
    logic [215:0] o;
    logic [215:0] msk;
    if (amt >= 13'(fmau_pkg::WF)) begin
      o = {{(fmau_pkg::WF-1){1'b0}}, |v};
    end else begin
      msk = ~({fmau_pkg::WF{1'b1}} << amt[7:0]);
      o = v >> amt[7:0];
      o[0] = o[0] | (|(v & msk));
    end
    return o;
  endfunction

  // Position of the highest set bit; a zero sum gives zero, which the caller handles apart.
  function automatic logic [7:0] lead_one(input logic [216:0] s);
    logic [7:0] l;
    l = 8'h00;
    for (int i = 0; i <= fmau_pkg::WF; i++) begin
      if (s[i]) begin
        l = 8'(i);
      end
    end
    return l;
  endfunction

  // The whole operation completes in one cycle: decode, classify, fused sum, one rounding, flag merge.
  // The wide datapath costs area, but it keeps the unit free of any multi-cycle hazard.
  function automatic fmau_pkg::fmau_res_t fma_exec(input fmau_pkg::fmau_regs_t s);
    fmau_pkg::fmau_res_t o;
    fmau_pkg::fmau_insn_t in;
    fmau_pkg::fmau_fp_t a;
    fmau_pkg::fmau_fp_t b;
    fmau_pkg::fmau_fp_t c;
    logic dbl, ill, ns, sp, sc, sr, pz, mul_inv, carry, nx, to_inf, unf;
    logic [105:0] mp;
    logic signed [12:0] ep, ec, d, eref, er, bexp, bias;
    logic [215:0] pw, cw;
    logic [216:0] sum, t;
    logic [7:0] ld;
    logic [52:0] m;
    logic g, st, inc;
    logic [53:0] mr;
    logic [10:0] emax;
    logic [51:0] frac;
    logic [4:0] fl, tb;
    o = '0;
    in = s.insn;
    ns = s.fsr.fp_nonstandard_mode;
    dbl = in.size == fmau_pkg::SIZE_D;
    ill = (in.op != fmau_pkg::OP_FMT) || (in.op3 != fmau_pkg::OP3_IMPL_OPCODE_SPACE_TWO) ||
          !((in.size == fmau_pkg::SIZE_S) || dbl);
    emax = dbl ? fmau_pkg::EMAX_D : fmau_pkg::EMAX_S;
    bias = dbl ? fmau_pkg::BIAS_D : fmau_pkg::BIAS_S;
    a = unpack(s.opnd[0], dbl);
    b = unpack(s.opnd[1], dbl);
    c = unpack(s.opnd[2], dbl);
    // In nonstandard mode a denormal addend is read as a signed zero.
    if (ns && c.den) begin
      c.m = 53'h0;
      c.zero = 1'b1;
      c.den = 1'b0;
    end
    // Variant bit 1 negates the product, bit 0 subtracts the addend.
    sp = a.sign ^ b.sign ^ (in.fvar == fmau_pkg::VAR_NMADD || in.fvar == fmau_pkg::VAR_NMSUB);
    sc = c.sign ^ (in.fvar == fmau_pkg::VAR_MSUB || in.fvar == fmau_pkg::VAR_NMADD);
    pz = a.zero | b.zero;
    mul_inv = a.snan | b.snan | (a.inf & b.zero) | (a.zero & b.inf);
    // The product is kept whole and the operand with the smaller exponent is aligned against the other with a wide guard field.
    mp = a.m * b.m;
    ep = a.e + b.e;
    ec = c.zero ? ep : c.e;
    d = ep - ec;
    pw = {mp, {fmau_pkg::GUARD{1'b0}}};
    cw = c.zero ? '0 : {1'b0, c.m, 52'h0, {fmau_pkg::GUARD{1'b0}}};
    if (d >= 13'sh0) begin
      cw = shr_sticky(cw, d);
      eref = ep;
    end else begin
      pw = shr_sticky(pw, -d);
      eref = ec;
    end
    if (sp == sc) begin
      sum = {1'b0, pw} + {1'b0, cw};
      sr = sp;
    end else if (pw >= cw) begin
      sum = {1'b0, pw - cw};
      sr = sp;
    end else begin
      sum = {1'b0, cw - pw};
      sr = sc;
    end
    ld = lead_one(sum);
    er = eref - PROD_SCALE_TOP + $signed({5'h0, ld});
    t = sum << (fmau_pkg::FIELD_TOP - ld);
    if (dbl) begin
      m = t[fmau_pkg::WF -: fmau_pkg::PD];
      g = t[fmau_pkg::WF-fmau_pkg::PD];
      st = |t[fmau_pkg::WF-fmau_pkg::PD-1:0];
    end else begin
      m = {{(fmau_pkg::PD-fmau_pkg::PS){1'b0}}, t[fmau_pkg::WF -: fmau_pkg::PS]};
      g = t[fmau_pkg::WF-fmau_pkg::PS];
      st = |t[fmau_pkg::WF-fmau_pkg::PS-1:0];
    end
    nx = g | st;
    // The single rounding step follows the selected mode.
    case (s.fsr.rnd)
      fmau_pkg::RM_NEAR: inc = g & (st | m[0]);
      fmau_pkg::RM_ZERO: inc = 1'b0;
      fmau_pkg::RM_PINF: inc = !sr & nx;
      fmau_pkg::RM_MINF: inc = sr & nx;
      default: inc = 1'b0;
    endcase
    mr = {1'b0, m} + {53'h0, inc};
    carry = dbl ? mr[fmau_pkg::PD] : mr[fmau_pkg::PS];
    if (carry) begin
      er = er + 13'sh1;
    end
    bexp = er + bias;
    frac = dbl ? mr[fmau_pkg::PD-2:0] : {mr[fmau_pkg::PS-2:0], {fmau_pkg::FPAD{1'b0}}};
    // Overflow goes to infinity in nearest mode, or when the directed mode rounds away from zero for this sign.
    to_inf = (s.fsr.rnd == fmau_pkg::RM_NEAR) || (s.fsr.rnd == fmau_pkg::RM_PINF && !sr) ||
             (s.fsr.rnd == fmau_pkg::RM_MINF && sr);
    fl = 5'h00;
    unf = 1'b0;
    // The size is judged before the enable, so a bad size traps as illegal even when disabled.
    if (ill) begin
      o.trap = fmau_pkg::TRAP_ILLEGAL;
    end else if (!s.fp_en) begin
      o.trap = fmau_pkg::TRAP_FP_DISABLED;
    end else if (ns && (a.den || b.den)) begin
      o.trap = fmau_pkg::TRAP_INCOMPLETE_FP_OPERATION;
    end else if (!ns && (a.den || b.den || c.den)) begin
      o.trap = fmau_pkg::TRAP_INCOMPLETE_FP_OPERATION;
    end else if (mul_inv && (s.fsr.tem & fmau_pkg::FL_NV) != 5'h00) begin
      // The addition is skipped and aexc stays as it was.
      o.trap = fmau_pkg::TRAP_IEEE;
      o.cexc = fmau_pkg::FL_NV;
    end else begin
      if (a.nan || b.nan || c.nan) begin
        // The chosen NaN keeps its own sign even for the negated forms.
        if (a.nan) o.val = pack(a.sign, emax, a.fr | fmau_pkg::QUIET_BIT, dbl);
        else if (b.nan) o.val = pack(b.sign, emax, b.fr | fmau_pkg::QUIET_BIT, dbl);
        else o.val = pack(c.sign, emax, c.fr | fmau_pkg::QUIET_BIT, dbl);
        fl = (mul_inv || c.snan) ? fmau_pkg::FL_NV : 5'h00;
      end else if (mul_inv) begin
        o.val = pack(1'b0, emax, fmau_pkg::FRAC_ONES, dbl);
        fl = fmau_pkg::FL_NV;
      end else if (a.inf || b.inf) begin
        if (c.inf && sc != sp) begin
          o.val = pack(1'b0, emax, fmau_pkg::FRAC_ONES, dbl);
          fl = fmau_pkg::FL_NV;
        end else begin
          o.val = pack(sp, emax, 52'h0, dbl);
        end
      end else if (c.inf) begin
        o.val = pack(sc, emax, 52'h0, dbl);
      end else if (pz && c.zero) begin
        o.val = pack((sp == sc) ? sp : (s.fsr.rnd == fmau_pkg::RM_MINF), 11'h000, 52'h0, dbl);
      end else if (pz) begin
        o.val = pack(sc, c.ex, c.fr, dbl);
      end else if (sum == '0) begin
        o.val = pack(s.fsr.rnd == fmau_pkg::RM_MINF, 11'h000, 52'h0, dbl);
      end else if (bexp >= $signed({2'h0, emax})) begin
        o.val = to_inf ? pack(sr, emax, 52'h0, dbl) : pack(sr, emax - 11'h001, fmau_pkg::FRAC_ONES, dbl);
        fl = fmau_pkg::FL_OF | fmau_pkg::FL_NX;
      end else if (bexp <= 13'sh0) begin
        // Tiny results are flushed in nonstandard mode, otherwise left to software.
        if (ns) begin
          o.val = pack(sr, 11'h000, 52'h0, dbl);
          fl = fmau_pkg::FL_UF | fmau_pkg::FL_NX;
        end else begin
          unf = 1'b1;
        end
      end else begin
        o.val = pack(sr, bexp[10:0], frac, dbl);
        fl = nx ? fmau_pkg::FL_NX : 5'h00;
      end
      tb = fl & s.fsr.tem;
      if (unf) begin
        o.trap = fmau_pkg::TRAP_INCOMPLETE_FP_OPERATION;
      end else if (tb != 5'h00) begin
        o.trap = fmau_pkg::TRAP_IEEE;
        o.cexc = tb;
      end else begin
        o.cexc = fl;
        o.wr = 1'b1;
      end
    end
    return o;
  endfunction

  // Register read view; write-only and unmapped offsets read as zero.
  function automatic logic [31:0] read_mux(input fmau_pkg::fmau_regs_t s, input logic [7:0] a);
    logic [31:0] v;
    case (a)
      fmau_pkg::REG_CTRL: v = {30'h0, s.fp_en, 1'b0};
      fmau_pkg::REG_INSN: v = s.insn;
      fmau_pkg::REG_FSR: v = s.fsr;
      fmau_pkg::REG_STATUS: v = {23'h0, s.dest, s.trap, s.st == fmau_pkg::ST_EXEC};
      fmau_pkg::REG_OP1_HI: v = s.opnd[0][63:32];
      fmau_pkg::REG_OP1_LO: v = s.opnd[0][31:0];
      fmau_pkg::REG_OP2_HI: v = s.opnd[1][63:32];
      fmau_pkg::REG_OP2_LO: v = s.opnd[1][31:0];
      fmau_pkg::REG_OP3_HI: v = s.opnd[2][63:32];
      fmau_pkg::REG_OP3_LO: v = s.opnd[2][31:0];
      fmau_pkg::REG_RES_HI: v = s.res[63:32];
      fmau_pkg::REG_RES_LO: v = s.res[31:0];
      fmau_pkg::REG_IRQ_STAT: v = {30'h0, s.irq_stat};
      fmau_pkg::REG_IRQ_EN: v = {30'h0, s.irq_en};
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  fmau_pkg::fmau_res_t ex;
  logic [1:0] irq_set;
  logic addr_ok;

  // One process computes the whole next state; the flop below only registers it.
  always_comb begin
    n = r;
    n.hready = 1'b1;
    irq_set = 2'h0;
    ex = fma_exec(r);
    addr_ok = haddr[31:8] == 24'h0;
    // Data phase of a write taken in the previous cycle.
    if (r.wr_pend) begin
      case (r.wr_addr)
        fmau_pkg::REG_CTRL: begin
          n.fp_en = hwdata[fmau_pkg::CTRL_FP_EN];
          if (hwdata[fmau_pkg::CTRL_START] && r.st == fmau_pkg::ST_IDLE) begin
            n.st = fmau_pkg::ST_EXEC;
          end
        end
        fmau_pkg::REG_INSN: n.insn = hwdata;
        fmau_pkg::REG_FSR: begin
          n.fsr = hwdata;
          n.fsr.rsv_a = 2'h0;
          n.fsr.rsv_b = 12'h000;
        end
        fmau_pkg::REG_OP1_HI: n.opnd[0][63:32] = hwdata;
        fmau_pkg::REG_OP1_LO: n.opnd[0][31:0] = hwdata;
        fmau_pkg::REG_OP2_HI: n.opnd[1][63:32] = hwdata;
        fmau_pkg::REG_OP2_LO: n.opnd[1][31:0] = hwdata;
        fmau_pkg::REG_OP3_HI: n.opnd[2][63:32] = hwdata;
        fmau_pkg::REG_OP3_LO: n.opnd[2][31:0] = hwdata;
        fmau_pkg::REG_IRQ_CLR: n.irq_stat = r.irq_stat & ~hwdata[1:0];
        fmau_pkg::REG_IRQ_EN: n.irq_en = hwdata[1:0];
        default: n.wr_addr = r.wr_addr;
      endcase
    end
    // The execute state lasts one cycle and reports through status, flags and interrupt bits.
    case (r.st)
      fmau_pkg::ST_EXEC: begin
        n.st = fmau_pkg::ST_IDLE;
        n.trap = ex.trap;
        n.dest = r.insn.rd;
        if (ex.wr) begin
          n.res = ex.val;
          n.fsr.cexc = ex.cexc;
          n.fsr.aexc = n.fsr.aexc | ex.cexc;
        end else if (ex.trap == fmau_pkg::TRAP_IEEE) begin
          n.fsr.cexc = ex.cexc;
        end
        irq_set[fmau_pkg::IRQ_DONE] = 1'b1;
        irq_set[fmau_pkg::IRQ_TRAP] = ex.trap != fmau_pkg::TRAP_NONE;
      end
      fmau_pkg::ST_IDLE: n.st = n.st;
      default: n.st = fmau_pkg::ST_IDLE;
    endcase
    // A new event outweighs a clear written in the same cycle.
    n.irq_stat = n.irq_stat | irq_set;
    n.irq = |(n.irq_stat & n.irq_en);
    // A write address phase is taken now; its data arrive in the next cycle.
    n.wr_pend = hsel && hready && htrans[1] && hwrite;
    n.wr_addr = addr_ok ? haddr[7:0] : fmau_pkg::REG_NONE;
    // Reads see any write finishing in this cycle.
    if (hsel && hready && htrans[1] && !hwrite) begin
      n.hrdata = addr_ok ? read_mux(n, haddr[7:0]) : 32'h0;
    end
  end

  // The bus never waits, so the ready flop comes out of reset set.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.hready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Every answer is OKAY, so the response needs no flop.
  assign hreadyout = r.hready;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign irq = r.irq;

endmodule

`default_nettype wire

// ===== hw/fmau_pkg.sv
// Shared types and constants of the fused multiply-add execution unit.
package fmau_pkg;

  // Instruction word layout, most significant field first.
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] rd;
    logic [5:0] op3;
    logic [4:0] rs1;
    logic [4:0] third_source_operand;
    logic [1:0] fvar;
    logic [1:0] size;
    logic [4:0] rs2;
  } fmau_insn_t;

  localparam logic [1:0] OP_FMT = 2'h2;
  localparam logic [5:0] OP3_IMPL_OPCODE_SPACE_TWO = 6'h37;
  localparam logic [1:0] VAR_MADD = 2'h0;
  localparam logic [1:0] VAR_MSUB = 2'h1;
  localparam logic [1:0] VAR_NMSUB = 2'h2;
  localparam logic [1:0] VAR_NMADD = 2'h3;
  localparam logic [1:0] SIZE_S = 2'h1;
  localparam logic [1:0] SIZE_D = 2'h2;

  // Status register: rounding mode, trap enables, mode bit, accrued and current flags.
  typedef struct packed {
    logic [1:0] rnd;
    logic [1:0] rsv_a;
    logic [4:0] tem;
    logic fp_nonstandard_mode;
    logic [11:0] rsv_b;
    logic [4:0] aexc;
    logic [4:0] cexc;
  } fmau_fsr_t;

  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_PINF = 2'h2;
  localparam logic [1:0] RM_MINF = 2'h3;

  // Flag bit order in cexc, aexc and tem.
  localparam logic [4:0] FL_NV = 5'h10;
  localparam logic [4:0] FL_OF = 5'h08;
  localparam logic [4:0] FL_UF = 5'h04;
  localparam logic [4:0] FL_NX = 5'h01;

  typedef enum logic [2:0] {
    TRAP_NONE = 3'h0,
    TRAP_FP_DISABLED = 3'h1,
    TRAP_ILLEGAL = 3'h2,
    TRAP_IEEE = 3'h3,
    TRAP_INCOMPLETE_FP_OPERATION = 3'h4
  } fmau_trap_t;

  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_EXEC = 1'h1
  } fmau_state_t;

  // Unpacked operand; the fraction is left aligned to the double width.
  typedef struct packed {
    logic sign;
    logic [10:0] ex;
    logic [51:0] fr;
    logic [52:0] m;
    logic signed [12:0] e;
    logic zero;
    logic den;
    logic inf;
    logic nan;
    logic snan;
  } fmau_fp_t;

  typedef struct packed {
    fmau_trap_t trap;
    logic [4:0] cexc;
    logic [63:0] val;
    logic wr;
  } fmau_res_t;

  localparam logic signed [12:0] BIAS_S = 13'h007f;
  localparam logic signed [12:0] BIAS_D = 13'h03ff;
  localparam logic [10:0] EMAX_S = 11'h0ff;
  localparam logic [10:0] EMAX_D = 11'h7ff;
  localparam logic [51:0] FRAC_ONES = 52'hfffffffffffff;
  localparam logic [51:0] QUIET_BIT = 52'h8000000000000;
  localparam int PD = 53;
  localparam int PS = 24;
  localparam int EWS = 8;
  localparam int FPAD = 29;
  localparam int GUARD = 110;
  localparam int WF = 216;
  localparam logic [7:0] FIELD_TOP = 8'hd8;
  localparam logic signed [12:0] PROD_SCALE = 13'h0068;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSN = 8'h04;
  localparam logic [7:0] REG_FSR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_OP1_HI = 8'h10;
  localparam logic [7:0] REG_OP1_LO = 8'h14;
  localparam logic [7:0] REG_OP2_HI = 8'h18;
  localparam logic [7:0] REG_OP2_LO = 8'h1c;
  localparam logic [7:0] REG_OP3_HI = 8'h20;
  localparam logic [7:0] REG_OP3_LO = 8'h24;
  localparam logic [7:0] REG_RES_HI = 8'h28;
  localparam logic [7:0] REG_RES_LO = 8'h2c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h30;
  localparam logic [7:0] REG_IRQ_CLR = 8'h34;
  localparam logic [7:0] REG_IRQ_EN = 8'h38;
  localparam logic [7:0] REG_NONE = 8'hff;
  localparam int CTRL_START = 0;
  localparam int CTRL_FP_EN = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRAP = 1;

  typedef struct packed {
    fmau_state_t st;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic fp_en;
    fmau_insn_t insn;
    fmau_fsr_t fsr;
    logic [2:0][63:0] opnd;
    logic [63:0] res;
    fmau_trap_t trap;
    logic [4:0] dest;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] hrdata;
    logic irq;
    logic hready;
  } fmau_regs_t;

endpackage

// ===== sim/fmau_checker.sv
// Port-level assertions for the fused multiply-add unit.
`timescale 1ns/1ps
`default_nettype none
module fmau_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Bus and interrupt
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq
);
  logic rd_ap;
  logic [3:0] age_r;
  assign rd_ap = hsel & hready & htrans[1] & ~hwrite;
  // The interrupt level may only move shortly after a control, clear or enable write.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      age_r <= 4'hf;
    end else if (hsel && hready && htrans[1] && hwrite && haddr[7:0] inside {8'h00, 8'h34, 8'h38}) begin
      age_r <= 4'h0;
    end else if (age_r != 4'hf) begin
      age_r <= age_r + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  ready_high_a: assert property (hreadyout == 1'b1) else $error("wait state inserted");
  irq_rise_a: assert property ($rose(irq) |-> age_r <= 4'h6) else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> age_r <= 4'h6) else $error("irq fell without cause");
  rdata_hold_a: assert property (!$past(rd_ap) |-> $stable(hrdata)) else $error("hrdata moved");
  unmapped_zero_a: assert property (rd_ap && (haddr[31:8] != 24'h0 || haddr[7:0] > 8'h38 || haddr[7:0] == 8'h34)
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  ctrl_read_a: assert property (rd_ap && haddr == 32'h0 |=> hrdata[31:2] == 30'h0 && !hrdata[0])
    else $error("ctrl readback wrong");
  status_trap_a: assert property (rd_ap && haddr == 32'hc |=> hrdata[31:9] == 23'h0 && hrdata[3:1] <= 3'h4)
    else $error("status code out of range");
  fsr_rsv_a: assert property (rd_ap && haddr == 32'h8 |=> hrdata[29:28] == 2'h0 && hrdata[21:10] == 12'h0)
    else $error("fsr reserved bits set");
  irq_cv: cover property ($rose(irq));
  trap_cv: cover property (rd_ap && haddr == 32'hc ##1 hrdata[3:1] != 3'h0);
  unmapped_cv: cover property (rd_ap && haddr[7:0] == 8'h40);
endmodule
`default_nettype wire

// ===== sim/fmau_ahb_host.sv
// AHB-Lite master standing in for the issue logic that loads and starts the unit.
`timescale 1ns/1ps
`default_nettype none
module fmau_ahb_host (
  // Clock and bus answer
  input wire logic ref_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
  end
  // One single word transfer; no wait-state count is assumed, only hready is trusted.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// ===== sim/fmau_top_test.sv
// Self-checking bench for the fused multiply-add unit over its register port.
`timescale 1ns/1ps
`default_nettype none
module fmau_top_test;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic unit_on = 1'b1;
  wire logic hsel;
  wire logic [31:0] haddr;
  wire logic [1:0] htrans;
  wire logic hwrite;
  wire logic [2:0] hsize;
  wire logic [31:0] hwdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic irq;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [7:0] zero_regs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h28, 8'h2c, 8'h30, 8'h38};
  logic [31:0] var_res [4] = '{32'h40e00000, 32'h40a00000, 32'hc0a00000, 32'hc0e00000};
  always #4 ref_clk = ~ref_clk;
  fmau_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .irq(irq));
  fmau_ahb_host u_host (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_host.xfer(1'b1, {24'h0, a}, d, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_host.xfer(1'b0, {24'h0, a}, 32'h0, r);
    chk(r, e);
  endtask
  function automatic logic [31:0] fsr_w(input logic [1:0] rm, input logic [4:0] tem, input logic ns,
    input logic [4:0] ax, input logic [4:0] cx);
    return {rm, 2'h0, tem, ns, 12'h0, ax, cx};
  endfunction
  // Loads one instruction with rd 5, rs1 1, third operand 3, rs2 2, starts it and checks status, result and flags.
  task automatic fma(input logic [1:0] v, input logic [1:0] sz, input logic [63:0] a, input logic [63:0] b,
    input logic [63:0] c, input logic [2:0] tr, input logic [63:0] er, input logic [31:0] ef);
    logic [2:0][63:0] o;
    logic [31:0] r;
    int n;
    o = {c, b, a};
    wr(8'h04, {2'h2, 5'h05, 6'h37, 5'h01, 5'h03, v, sz, 5'h02});
    for (int i = 0; i < 3; i++) begin
      wr(8'h10 + 8'(8 * i), o[i][63:32]);
      wr(8'h14 + 8'(8 * i), o[i][31:0]);
    end
    wr(8'h00, {30'h0, unit_on, 1'b1});
    n = 0;
    do begin
      u_host.xfer(1'b0, 32'hc, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 20);
    chk(r, {23'h0, 5'h05, tr, 1'b0});
    rdchk(8'h2c, er[31:0]);
    rdchk(8'h28, er[63:32]);
    rdchk(8'h08, ef);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (zero_regs[i])
      rdchk(zero_regs[i], 32'h0);
    wr(8'h38, 32'h1);
    for (int v = 0; v < 4; v++)
      fma(v[1:0], 2'h1, 32'h40000000, 32'h40400000, 32'h3f800000, 3'h0, var_res[v], 32'h0);
    rdchk(8'h00, 32'h2);
    chk(irq, 1'b1);
    wr(8'h34, 32'h1);
    rdchk(8'h30, 32'h0);
    chk(irq, 1'b0);
    wr(8'h38, 32'h0);
    fma(2'h0, 2'h2, 64'h4000000000000000, 64'h4008000000000000, 64'h3ff0000000000000, 3'h0,
      64'h401c000000000000, 32'h0);
    chk(irq, 1'b0);
    rdchk(8'h30, 32'h1);
    wr(8'h38, 32'h3);
    rdchk(8'h38, 32'h3);
    chk(irq, 1'b1);
    wr(8'h34, 32'h1);
    // Exact product minus a nearby value: a rounded product would give zero here.
    fma(2'h1, 2'h1, 32'h3f800800, 32'h3f800800, 32'h3f801000, 3'h0, 32'h33800000, 32'h0);
    wr(8'h08, fsr_w(2'h2, 5'h0, 1'b0, 5'h0, 5'h0));
    fma(2'h0, 2'h1, 32'h3f800000, 32'h3f800000, 32'h33800000, 3'h0, 32'h3f800001, 32'h80000021);
    wr(8'h08, fsr_w(2'h1, 5'h0, 1'b0, 5'h0, 5'h0));
    fma(2'h0, 2'h1, 32'h3f800000, 32'h3f800000, 32'h33800000, 3'h0, 32'h3f800000, 32'h40000021);
    wr(8'h08, fsr_w(2'h3, 5'h0, 1'b0, 5'h0, 5'h0));
    fma(2'h3, 2'h1, 32'h3f800000, 32'h3f800000, 32'h33800000, 3'h0, 32'hbf800001, 32'hc0000021);
    wr(8'h08, 32'h0);
    fma(2'h0, 2'h1, 32'h3f800000, 32'h3f800000, 32'h33800000, 3'h0, 32'h3f800000, 32'h21);
    wr(8'h08, 32'h0);
    fma(2'h3, 2'h1, 32'hffc00001, 32'h40000000, 32'h3f800000, 3'h0, 32'hffc00001, 32'h0);
    fma(2'h2, 2'h1, 32'h40000000, 32'h7fc00002, 32'h3f800000, 3'h0, 32'h7fc00002, 32'h0);
    fma(2'h0, 2'h1, 32'h7f800000, 32'h0, 32'h3f800000, 3'h0, 32'h7fffffff, 32'h210);
    wr(8'h08, fsr_w(2'h0, fmau_pkg::FL_NV, 1'b0, 5'h0, 5'h0));
    fma(2'h0, 2'h1, 32'h7f800000, 32'h0, 32'h3f800000, 3'h3, 32'h7fffffff,
      fsr_w(2'h0, fmau_pkg::FL_NV, 1'b0, 5'h0, fmau_pkg::FL_NV));
    rdchk(8'h30, 32'h3);
    wr(8'h34, 32'h3);
    wr(8'h08, 32'hffffffff);
    rdchk(8'h08, 32'hcfc003ff);
    wr(8'h08, 32'h0);
    fma(2'h0, 2'h1, 32'h7f7fffff, 32'h40000000, 32'h0, 3'h0, 32'h7f800000, 32'h129);
    wr(8'h08, fsr_w(2'h0, fmau_pkg::FL_OF, 1'b0, 5'h0, 5'h0));
    fma(2'h0, 2'h1, 32'h7f7fffff, 32'h40000000, 32'h0, 3'h3, 32'h7f800000,
      fsr_w(2'h0, fmau_pkg::FL_OF, 1'b0, 5'h0, fmau_pkg::FL_OF));
    wr(8'h08, fsr_w(2'h0, 5'h0, 1'b1, 5'h0, 5'h0));
    fma(2'h0, 2'h1, 32'h0d800000, 32'h30800000, 32'h0, 3'h0, 32'h0, fsr_w(2'h0, 5'h0, 1'b1, 5'h05, 5'h05));
    fma(2'h0, 2'h1, 32'h1, 32'h40000000, 32'h0, 3'h4, 32'h0, fsr_w(2'h0, 5'h0, 1'b1, 5'h05, 5'h05));
    wr(8'h08, 32'h0);
    fma(2'h0, 2'h1, 32'h1, 32'h40000000, 32'h0, 3'h4, 32'h0, 32'h0);
    unit_on = 1'b0;
    fma(2'h0, 2'h0, 32'h40000000, 32'h40400000, 32'h3f800000, 3'h2, 32'h0, 32'h0);
    fma(2'h0, 2'h3, 32'h40000000, 32'h40400000, 32'h3f800000, 3'h2, 32'h0, 32'h0);
    fma(2'h0, 2'h1, 32'h40000000, 32'h40400000, 32'h3f800000, 3'h1, 32'h0, 32'h0);
    wr(8'h40, 32'hffffffff);
    rdchk(8'h40, 32'h0);
    u_host.xfer(1'b0, 32'h104, 32'h0, q);
    chk(q, 32'h0);
    tally_and_finish();
  end
endmodule
bind fmau_top fmau_checker u_chk (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
`default_nettype wire
